/* File: pic_pkg.sv */
// Constants, field layouts and state encoding for the priority interrupt controller
package pic_pkg;
   // Source rank: index 0 wins ties
   localparam int unsigned NUM_SRC = 14;
   localparam int unsigned NUM_INT = 12;
   localparam logic [3:0] SRC_EXT1 = 4'h0;
   localparam logic [3:0] SRC_EXT0 = 4'h1;
   localparam logic [3:0] SRC_INT0 = 4'h2;
   localparam int unsigned NUM_PIN = 4;

   // Wishbone byte offsets
   localparam logic [7:0] OFS_EXT_BASE  = 8'h00;
   localparam logic [7:0] OFS_INT_BASE  = 8'h04;
   localparam logic [7:0] OFS_PRIO_STK  = 8'h08;
   localparam logic [7:0] OFS_EXT0_CTRL = 8'h0C;
   localparam logic [7:0] OFS_EXT1_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h14;

   // External control fields
   localparam int unsigned CTL_LVL_LSB  = 0;
   localparam int unsigned CTL_EDGA_LSB = 2;
   localparam int unsigned CTL_EDGB_LSB = 4;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Reset values
   localparam logic [7:0]  PRIO_STK_RST = 8'hFF;
   localparam logic [7:0]  BASE_RST     = 8'h00;
   localparam logic [5:0]  CTRL_RST     = 6'h00;
   localparam logic [15:0] SP_RST       = 16'h0000;
   localparam logic [15:0] PC_RST       = 16'h0000;

   // Vector low bytes
   localparam logic [7:0] VEC_EXT0 = 8'h00;
   localparam logic [7:0] VEC_EXT1 = 8'h08;
   localparam int unsigned VEC_SHIFT = 4;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_ACK, ST_PUSH_HI, ST_PUSH_LO, ST_JUMP
   } pic_state_t;
endpackage : pic_pkg

/* File: pic_edge_catch.sv */
// Edge catcher for one external interrupt pin
`timescale 1ns/1ps
module pic_edge_catch (
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       clr_i,
   output logic            caught_o
);
   logic prev_q;
   logic valid_q;
   logic rise;
   logic fall;
   logic hit;

   assign rise = valid_q & pin_i & ~prev_q;
   assign fall = valid_q & ~pin_i & prev_q;
   assign hit  = (rise & mode_i[1]) | (fall & mode_i[0]);

   // Pin history is not trusted until one sample has been taken
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         prev_q  <= pin_i;
         valid_q <= 1'b1;
      end
   end

   // Edge in the clearing cycle is kept
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         caught_o <= 1'b0;
      end else if (hit) begin
         caught_o <= 1'b1;
      end else if (clr_i) begin
         caught_o <= 1'b0;
      end
   end
endmodule : pic_edge_catch

/* File: pic_prio_stack.sv */
// Four-entry processor priority stack
`timescale 1ns/1ps
module pic_prio_stack (
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       push_i,
   input  wire logic [1:0] lvl_i,
   input  wire logic       pop_i,
   output logic [7:0]      stack_o
);
   // Low two bits are the running priority
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stack_o <= pic_pkg::PRIO_STK_RST;
      end else if (push_i) begin
         stack_o <= {stack_o[5:0], lvl_i};
      end else if (pop_i) begin
         stack_o <= {stack_o[1:0], stack_o[7:2]};
      end else if (wr_i) begin
         stack_o <= wdata_i;
      end
   end
endmodule : pic_prio_stack

/* File: pic_ctrl.sv */
// Prioritized interrupt controller top with Wishbone register slave
`timescale 1ns/1ps
module pic_ctrl (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // External interrupt pins: ext0 A/B, ext1 A/B
   input  wire logic [3:0]  ext_pin_i,
   // Internal sources in rank order
   input  wire logic [11:0] int_set_i,
   input  wire logic [11:0] int_clr_i,
   input  wire logic [23:0] int_lvl_i,
   // Processor core
   input  wire logic        insn_end_i,
   input  wire logic        prio_pop_i,
   input  wire logic [15:0] pc_i,
   output logic             ack_cycle_o,
   output logic             push_wr_o,
   output logic [15:0]      push_addr_o,
   output logic [7:0]       push_data_o,
   output logic             jump_o,
   output logic [15:0]      jump_pc_o,
   output logic [1:0]       cur_prio_o
);
   localparam int unsigned NS = pic_pkg::NUM_SRC;

   // Winner search: highest level first, then lowest rank index
   function automatic logic [6:0] pick(input logic [13:0] req,
                                       input logic [27:0] lvl,
                                       input logic [1:0]  cur);
      logic [1:0] best;
      logic [3:0] idx;
      logic       found;
      best  = 2'h0;
      idx   = 4'h0;
      found = 1'b0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (req[i] && (lvl[2*i +: 2] > cur) && (lvl[2*i +: 2] >= best)) begin
            best  = lvl[2*i +: 2];
            idx   = 4'(i);
            found = 1'b1;
         end
      end
      return {found, idx, best};
   endfunction : pick

   function automatic logic [7:0] vec_low(input logic [3:0] idx);
      logic [3:0] n;
      n = idx - pic_pkg::SRC_INT0;
      if (idx == pic_pkg::SRC_EXT0) begin
         vec_low = pic_pkg::VEC_EXT0;
      end else if (idx == pic_pkg::SRC_EXT1) begin
         vec_low = pic_pkg::VEC_EXT1;
      end else begin
         vec_low = 8'({n, 4'h0});
      end
   endfunction : vec_low

   logic [7:0]        ext_base_q;
   logic [7:0]        int_base_q;
   logic [5:0]        ext_ctrl_q [2];
   logic [7:0]        stack;
   logic [3:0]        caught;
   logic [1:0]        ext_req;
   logic [11:0]       int_q;
   logic [13:0]       req;
   logic [27:0]       lvl;
   logic [6:0]        win;
   pic_pkg::pic_state_t state_q;
   logic [3:0]        sel_idx_q;
   logic [1:0]        sel_lvl_q;
   logic [15:0]       sp_q;
   logic [15:0]       pc_q;
   logic [1:0]        ext_clr;
   logic              wb_req;
   logic              wb_wr;
   logic              stk_wr;
   logic [31:0]       rd_d;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
   assign stk_wr = wb_wr & (wb_adr_i == pic_pkg::OFS_PRIO_STK);

   // Register writes; byte lane 0 carries all fields
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_base_q    <= pic_pkg::BASE_RST;
         int_base_q    <= pic_pkg::BASE_RST;
         ext_ctrl_q[0] <= pic_pkg::CTRL_RST;
         ext_ctrl_q[1] <= pic_pkg::CTRL_RST;
      end else if (wb_wr) begin
         unique case (wb_adr_i)
            pic_pkg::OFS_EXT_BASE:  ext_base_q    <= wb_dat_i[7:0];
            pic_pkg::OFS_INT_BASE:  int_base_q    <= wb_dat_i[7:0];
            pic_pkg::OFS_EXT0_CTRL: ext_ctrl_q[0] <= wb_dat_i[5:0];
            pic_pkg::OFS_EXT1_CTRL: ext_ctrl_q[1] <= wb_dat_i[5:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (wb_adr_i)
         pic_pkg::OFS_EXT_BASE:  rd_d[7:0]  = ext_base_q;
         pic_pkg::OFS_INT_BASE:  rd_d[7:0]  = int_base_q;
         pic_pkg::OFS_PRIO_STK:  rd_d[7:0]  = stack;
         pic_pkg::OFS_EXT0_CTRL: rd_d[5:0]  = ext_ctrl_q[0];
         pic_pkg::OFS_EXT1_CTRL: rd_d[5:0]  = ext_ctrl_q[1];
         pic_pkg::OFS_STATUS:    rd_d       = {9'h000, state_q, 6'h00, req};
         default:                rd_d       = 32'h0000_0000;
      endcase
   end

   // One wait state; unmapped addresses ack with zero data
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_d : 32'h0000_0000;
      end
   end

   // Pin catchers; both catchers of an interrupt clear on its acknowledge
   for (genvar g = 0; g < pic_pkg::NUM_PIN; g++) begin : g_catch
      pic_edge_catch u_catch (
         .clock_i  (clock_i),
         .nrst_i   (nrst_i),
         .pin_i    (ext_pin_i[g]),
         .mode_i   (ext_ctrl_q[g/2][(g%2 == 0 ? pic_pkg::CTL_EDGA_LSB
                                               : pic_pkg::CTL_EDGB_LSB) +: 2]),
         .clr_i    (ext_clr[g/2]),
         .caught_o (caught[g])
      );
   end

   assign ext_req[0] = caught[0] | caught[1];
   assign ext_req[1] = caught[2] | caught[3];

   // Only the acknowledge clears an external request
   assign ext_clr[0] = (state_q == pic_pkg::ST_ACK) && (sel_idx_q == pic_pkg::SRC_EXT0);
   assign ext_clr[1] = (state_q == pic_pkg::ST_ACK) && (sel_idx_q == pic_pkg::SRC_EXT1);

   // Internal request latches; a set in the clearing cycle wins
   for (genvar g = 0; g < pic_pkg::NUM_INT; g++) begin : g_int
      always_ff @(posedge clock_i or negedge nrst_i) begin
         if (!nrst_i) begin
            int_q[g] <= 1'b0;
         end else if (int_set_i[g]) begin
            int_q[g] <= 1'b1;
         end else if (int_clr_i[g]) begin
            int_q[g] <= 1'b0;
         end
      end
   end

   assign req = {int_q, ext_req[0], ext_req[1]};
   assign lvl = {int_lvl_i,
                 ext_ctrl_q[0][pic_pkg::CTL_LVL_LSB +: 2],
                 ext_ctrl_q[1][pic_pkg::CTL_LVL_LSB +: 2]};
   assign win = pick(req, lvl, stack[1:0]);

   pic_prio_stack u_stack (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .wr_i    (stk_wr),
      .wdata_i (wb_dat_i[7:0]),
      .push_i  (state_q == pic_pkg::ST_ACK),
      .lvl_i   (sel_lvl_q),
      .pop_i   (prio_pop_i),
      .stack_o (stack)
   );

   // Acceptance sequence
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q   <= pic_pkg::ST_IDLE;
         sel_idx_q <= 4'h0;
         sel_lvl_q <= 2'h0;
      end else begin
         unique case (state_q)
            pic_pkg::ST_IDLE: begin
               if (insn_end_i && win[6]) begin
                  state_q   <= pic_pkg::ST_ARMED;
                  sel_idx_q <= win[5:2];
                  sel_lvl_q <= win[1:0];
               end
            end
            pic_pkg::ST_ARMED: begin
               if (insn_end_i) begin
                  state_q <= pic_pkg::ST_ACK;
               end
            end
            pic_pkg::ST_ACK:     state_q <= pic_pkg::ST_PUSH_HI;
            pic_pkg::ST_PUSH_HI: state_q <= pic_pkg::ST_PUSH_LO;
            pic_pkg::ST_PUSH_LO: state_q <= pic_pkg::ST_JUMP;
            pic_pkg::ST_JUMP:    state_q <= pic_pkg::ST_IDLE;
            default:             state_q <= pic_pkg::ST_IDLE;
         endcase
      end
   end

   // Core-facing strobes; the fetched byte is dropped during the acknowledge
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_cycle_o <= 1'b0;
         push_wr_o   <= 1'b0;
         push_data_o <= 8'h00;
         push_addr_o <= pic_pkg::SP_RST;
         sp_q        <= pic_pkg::SP_RST;
         pc_q        <= pic_pkg::PC_RST;
      end else begin
         ack_cycle_o <= (state_q == pic_pkg::ST_ARMED) && insn_end_i;
         push_wr_o   <= 1'b0;
         if (state_q == pic_pkg::ST_ACK) begin
            pc_q        <= pc_i;
            push_wr_o   <= 1'b1;
            push_addr_o <= sp_q - 16'h0001;
            push_data_o <= pc_i[15:8];
            sp_q        <= sp_q - 16'h0001;
         end else if (state_q == pic_pkg::ST_PUSH_HI) begin
            push_wr_o   <= 1'b1;
            push_addr_o <= sp_q - 16'h0001;
            push_data_o <= pc_q[7:0];
            sp_q        <= sp_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         jump_o    <= 1'b0;
         jump_pc_o <= pic_pkg::PC_RST;
      end else begin
         jump_o <= (state_q == pic_pkg::ST_PUSH_LO);
         if (state_q == pic_pkg::ST_PUSH_LO) begin
            jump_pc_o <= {(sel_idx_q < pic_pkg::SRC_INT0) ? ext_base_q : int_base_q,
                          vec_low(sel_idx_q)};
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_prio_o <= pic_pkg::PRIO_STK_RST[1:0];
      end else begin
         cur_prio_o <= stack[1:0];
      end
   end

   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   property p_accept_above;
      $rose(state_q == pic_pkg::ST_ARMED) |-> sel_lvl_q > $past(stack[1:0]);
   endproperty
   a_accept_above: assert property (p_accept_above) else $error("low level accepted");

   property p_prio_set;
      state_q == pic_pkg::ST_ACK |=> stack[1:0] == $past(sel_lvl_q)
                                     && stack[7:2] == $past(stack[5:0]);
   endproperty
   a_prio_set: assert property (p_prio_set) else $error("priority not pushed");

   property p_two_pushes;
      ack_cycle_o |=> push_wr_o ##1 push_wr_o ##1 !push_wr_o && jump_o;
   endproperty
   a_two_pushes: assert property (p_two_pushes) else $error("push sequence wrong");

   property p_ext_clear;
      $fell(ext_req[0]) |-> $past(ext_clr[0]);
   endproperty
   a_ext_clear: assert property (p_ext_clear) else $error("ext0 cleared w/o ack");

   property p_ext_vec;
      jump_o && $past(sel_idx_q, 2) == pic_pkg::SRC_EXT1 |->
         jump_pc_o == {ext_base_q, pic_pkg::VEC_EXT1};
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("ext1 vector wrong");

   property p_int_vec;
      jump_o && sel_idx_q >= pic_pkg::SRC_INT0 |->
         jump_pc_o[15:8] == int_base_q && jump_pc_o[3:0] == 4'h0;
   endproperty
   a_int_vec: assert property (p_int_vec) else $error("internal vector wrong");

   property p_pop;
      prio_pop_i && state_q != pic_pkg::ST_ACK |=> stack[7:6] == $past(stack[1:0]);
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong");

   property p_set_wins;
      int_set_i[0] && int_clr_i[0] |=> int_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost");

   property p_rank;
      insn_end_i && state_q == pic_pkg::ST_IDLE && req[0] && req[1]
         && lvl[1:0] == lvl[3:2] && lvl[1:0] > stack[1:0] |=> sel_idx_q == pic_pkg::SRC_EXT1;
   endproperty
   a_rank: assert property (p_rank) else $error("rank order wrong");

   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing");

   // The copy is registered, so it trails the stack by one cycle
   property p_cur_prio;
      1'b1 |=> cur_prio_o == $past(stack[1:0]);
   endproperty
   a_cur_prio: assert property (p_cur_prio) else $error("running priority copy wrong");

   property p_ack_after;
      ack_cycle_o |-> $past(state_q) == pic_pkg::ST_ARMED && $past(insn_end_i);
   endproperty
   a_ack_after: assert property (p_ack_after) else $error("ack before instruction end");

   property p_ext_base;
      jump_o && sel_idx_q < pic_pkg::SRC_INT0 |->
         jump_pc_o[15:8] == ext_base_q;
   endproperty
   a_ext_base: assert property (p_ext_base) else $error("external base wrong");

   property p_vec_space;
      jump_o && sel_idx_q >= pic_pkg::SRC_INT0 |->
         jump_pc_o[7:4] == 4'(sel_idx_q - pic_pkg::SRC_INT0);
   endproperty
   a_vec_space: assert property (p_vec_space) else $error("vector spacing wrong");

   c_ext_taken: cover property (ext_clr[0]);
   c_int_taken: cover property (jump_o && sel_idx_q >= pic_pkg::SRC_INT0);
   c_nested:    cover property (state_q == pic_pkg::ST_ACK && stack[1:0] != 2'h0);
   c_rank_tie:  cover property (state_q == pic_pkg::ST_IDLE && insn_end_i && req[0] && req[1]);
   c_set_clear: cover property (int_set_i[0] && int_clr_i[0]);
endmodule : pic_ctrl

/* File: pic_core_model.sv */
// Processor core model that paces instructions and records the call pushes
`timescale 1ns/1ps
module pic_core_model (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        slow_i,
   input  wire logic        ack_cycle_i,
   input  wire logic        push_wr_i,
   input  wire logic [15:0] push_addr_i,
   input  wire logic [7:0]  push_data_i,
   input  wire logic        jump_i,
   input  wire logic [15:0] jump_pc_i,
   output logic             insn_end_o,
   output logic [15:0]      pc_o,
   output logic [15:0]      ack_pc_o,
   output logic [15:0]      push_bytes_o,
   output logic [31:0]      push_addrs_o
);
   logic [1:0] div_q;

   // Slow mode spaces instruction ends four cycles apart
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q      <= 2'h0;
         insn_end_o <= 1'b0;
      end else begin
         div_q      <= div_q + 2'h1;
         insn_end_o <= !slow_i || (div_q == 2'h3);
      end
   end

   // The core follows the vector, so a later call pushes the new address
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_o         <= 16'hC35A;
         ack_pc_o     <= 16'h0000;
         push_bytes_o <= 16'h0000;
         push_addrs_o <= 32'h0000_0000;
      end else begin
         if (jump_i) pc_o <= jump_pc_i;
         else if (insn_end_o) pc_o <= pc_o + 16'h0001;
         if (ack_cycle_i) ack_pc_o <= pc_o;
         if (push_wr_i) begin
            push_bytes_o <= {push_bytes_o[7:0], push_data_i};
            push_addrs_o <= {push_addrs_o[15:0], push_addr_i};
         end
      end
   end
endmodule : pic_core_model

/* File: priority_interrupt_controller_tb_top.sv */
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module priority_interrupt_controller_tb_top;
   logic        clock_i, nrst_i, slow;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, ext_pin_i;
   logic [31:0] wb_dat_i, wb_dat_o, push_addrs;
   logic [11:0] int_set_i, int_clr_i;
   logic [23:0] int_lvl_i;
   logic        insn_end_i, prio_pop_i, ack_cycle_o, push_wr_o, jump_o;
   logic [15:0] pc_i, push_addr_o, jump_pc_o, ack_pc, push_bytes, exp_sp;
   logic [7:0]  push_data_o;
   logic [1:0]  cur_prio_o;
   int          n_mismatch, comparisons, cycles;

   pic_ctrl dut (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pin_i(ext_pin_i), .int_set_i(int_set_i),
      .int_clr_i(int_clr_i), .int_lvl_i(int_lvl_i), .insn_end_i(insn_end_i),
      .prio_pop_i(prio_pop_i), .pc_i(pc_i), .ack_cycle_o(ack_cycle_o), .push_wr_o(push_wr_o),
      .push_addr_o(push_addr_o), .push_data_o(push_data_o), .jump_o(jump_o),
      .jump_pc_o(jump_pc_o), .cur_prio_o(cur_prio_o));

   pic_core_model core (.clock_i(clock_i), .nrst_i(nrst_i), .slow_i(slow),
      .ack_cycle_i(ack_cycle_o), .push_wr_i(push_wr_o), .push_addr_i(push_addr_o),
      .push_data_i(push_data_o), .jump_i(jump_o), .jump_pc_i(jump_pc_o),
      .insn_end_o(insn_end_i), .pc_o(pc_i), .ack_pc_o(ack_pc), .push_bytes_o(push_bytes),
      .push_addrs_o(push_addrs));

   always #5 clock_i = ~clock_i;

   task automatic summarize;
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   // Ceiling is well above the whole sequence, so only a hang reaches it
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                     input logic [3:0] sel, output logic [31:0] rd);
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h0, wd};
      do @(posedge clock_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [31:0] v;
      wb(1'b1, adr, wd, 4'hF, v);
   endtask : wr

   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] v;
      wb(1'b0, adr, 8'h00, 4'hF, v);
      check(v, exp);
   endtask : rdc

   // Peripheral latch set and clear strobes, one cycle each
   task automatic pulse(input logic [11:0] s, input logic [11:0] c);
      @(posedge clock_i);
      int_set_i <= s;
      int_clr_i <= c;
      @(posedge clock_i);
      int_set_i <= 12'h000;
      int_clr_i <= 12'h000;
   endtask : pulse

   task automatic pop;
      @(posedge clock_i);
      prio_pop_i <= 1'b1;
      @(posedge clock_i);
      prio_pop_i <= 1'b0;
   endtask : pop

   task automatic quiet(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge clock_i);
         if (ack_cycle_o === 1'b1) hits++;
      end
      check(32'(hits), 32'h0);
   endtask : quiet

   // Waits for the vector jump, then judges the call it completed
   task automatic serve(input logic [15:0] vec, input logic [1:0] lvl);
      @(posedge clock_i);
      while (jump_o !== 1'b1) @(posedge clock_i);
      check(32'(jump_pc_o), 32'(vec));
      check(32'(cur_prio_o), 32'(lvl));
      check(32'(push_bytes), 32'(ack_pc));
      check(push_addrs, {exp_sp - 16'h1, exp_sp - 16'h2});
      exp_sp = exp_sp - 16'h2;
   endtask : serve

   // Reset values and an unmapped address
   task automatic t_reset;
      rdc(8'h00, 32'h00);
      rdc(8'h04, 32'h00);
      rdc(8'h08, 32'hFF);
      rdc(8'h0C, 32'h00);
      rdc(8'h20, 32'h00);
      check(32'(cur_prio_o), 32'h3);
   endtask : t_reset

   // At priority three nothing may be taken; a set beside a clear is kept
   task automatic t_blocked;
      int_lvl_i <= 24'h000003;
      pulse(12'h001, 12'h001);
      rdc(8'h14, 32'h4);
      quiet(20);
      pulse(12'h000, 12'h001);
      rdc(8'h14, 32'h0);
   endtask : t_blocked

   // Single internal call, then a blocked equal level that is dropped
   task automatic t_single;
      int_lvl_i <= 24'h000020;
      wr(8'h04, 8'h40);
      wr(8'h08, 8'h00);
      pulse(12'h004, 12'h000);
      serve(16'h4020, 2'h2);
      rdc(8'h08, 32'h02);
      int_lvl_i <= 24'h0000A0;
      pulse(12'h008, 12'h000);
      quiet(20);
      pulse(12'h000, 12'h00C);
      pop();
      rdc(8'h08, 32'h80);
      check(32'(cur_prio_o), 32'h0);
      quiet(20);
   endtask : t_single

   // All internal sources at one level: fixed rank order
   task automatic t_rank;
      int_lvl_i <= 24'h555555;
      wr(8'h08, 8'h00);
      pulse(12'hFFF, 12'h000);
      for (int i = 0; i < 12; i++) begin
         serve({8'h40, 8'(i * 16)}, 2'h1);
         pulse(12'h000, 12'(1 << i));
         wr(8'h08, 8'h00);
      end
   endtask : t_rank

   // The worse-ranked source holds the higher level, so level must decide
   task automatic t_level;
      int_lvl_i <= 24'hC00400;
      pulse(12'h820, 12'h000);
      serve(16'h40B0, 2'h3);
      pulse(12'h000, 12'h800);
      pop();
      serve(16'h4050, 2'h1);
      pulse(12'h000, 12'h020);
   endtask : t_level

   // External pair with a slow core; ext0 pin A both edges, ext1 pin A rising and pin B falling; reads never clear
   task automatic t_external;
      slow      <= 1'b1;
      ext_pin_i <= 4'h8;
      wr(8'h08, 8'hFF);
      wr(8'h00, 8'h90);
      wr(8'h0C, 8'h0F);
      wr(8'h10, 8'h1B);
      rdc(8'h10, 32'h1B);
      ext_pin_i <= 4'h5;
      rdc(8'h14, 32'h3);
      rdc(8'h14, 32'h3);
      wr(8'h08, 8'h00);
      serve(16'h9008, 2'h3);
      rdc(8'h14, 32'h2);
      pop();
      serve(16'h9000, 2'h3);
      rdc(8'h14, 32'h0);
   endtask : t_external

   initial begin
      {clock_i, nrst_i, slow, wb_cyc_i, wb_stb_i, wb_we_i, prio_pop_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, ext_pin_i, int_set_i, int_clr_i, int_lvl_i} = '0;
      {n_mismatch, comparisons, cycles} = '0;
      exp_sp = 16'h0000;
      repeat (5) @(posedge clock_i);
      nrst_i <= 1'b1;
      t_reset();
      t_blocked();
      t_single();
      t_rank();
      t_level();
      t_external();
      summarize();
   end
endmodule : priority_interrupt_controller_tb_top
